//--- rtl/dcp_pkg.sv
// constants and types for the debug control port
package dcp_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses inside the port)
	// ----------------------------------------------------------------
	localparam logic [7:0] DCP_OFS_SOFT_RESET_HOLD = 8'h00;
	localparam logic [7:0] DCP_OFS_CHIP_ERASE_COMMAND = 8'h04;
	localparam logic [7:0] DCP_OFS_CHIP_ERASE_STATE = 8'h08;
	localparam logic [7:0] DCP_OFS_LOCK_STATE = 8'h0c;
	localparam logic [7:0] DCP_OFS_PORT_IDENT_WORD = 8'hfc;
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int DCP_BIT_FLAG = 0;
	localparam int DCP_IDENT_PORT_LSB = 0;
	localparam int DCP_IDENT_CLASS_LSB = 13;
	localparam int DCP_IDENT_MAKER_LSB = 17;
	localparam int DCP_IDENT_CONT_LSB = 24;
	localparam int DCP_IDENT_REV_LSB = 28;
	localparam logic [3:0] DCP_CLASS_NONE = 4'h0;
	localparam logic [3:0] DCP_CLASS_MEMORY_ACCESS = 4'h8;
	localparam logic DCP_RESET_RELEASED = 1'b0;
	localparam logic DCP_NO_ACTION = 1'b0;
	localparam logic [31:0] DCP_RESET_WORD = 32'h0000_0000;
	localparam int DCP_ADDR_W = 8;
	localparam int DCP_DATA_W = 32;
	// ----------------------------------------------------------------
	// handshake states and state record
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		DCP_HS_IDLE,
		DCP_HS_WAIT_DROP
	} dcp_hs_t;
	typedef struct packed {
		logic clk_s1;
		logic clk_s2;
		logic clk_s3;
		logic req_s1;
		logic req_s2;
		logic wr_s1;
		logic wr_s2;
		logic [DCP_ADDR_W-1:0] addr_s1;
		logic [DCP_ADDR_W-1:0] addr_s2;
		logic [DCP_DATA_W-1:0] wdata_s1;
		logic [DCP_DATA_W-1:0] wdata_s2;
		logic pwr_s1;
		logic pwr_s2;
		logic pwr_prev;
		logic lock_s1;
		logic lock_s2;
		dcp_hs_t hs;
		logic ack;
		logic [DCP_DATA_W-1:0] rdata;
		logic rst_hold;
		logic busy;
		logic erase_start;
		logic erase_config;
		logic dbg_mode;
		logic wake;
		logic wake_flag;
		logic irq_allow;
	} dcp_state_t;
endpackage : dcp_pkg

//--- rtl/dcp_control_port.sv
// debug control port: register access, erase, reset hold, debug mode
`timescale 1ns/1ns
// Notes on behaviour
// - port accesses work regardless of the protection lock input.
// - soft reset bit at 0x000 holds device in reset while set.
// - writing 1 at 0x004 starts chip erase; writing 0 does nothing.
// - chip erase also erases the user config block, clearing protection.
// - bit at 0x008 reads 1 while erase runs, 0 when ready.
// - bit at 0x00c reads 0 when protection active, 1 otherwise.
// - read-only identification word at 0x0fc with id, class, maker, revision fields.
// - power-up request during system off wakes device, sets debug wake flag.
// - debug mode lasts exactly while power-up request stays asserted.
// - while halted low, higher-priority interrupts still run to completion.
module dcp_control_port
	import dcp_pkg::*;
#(
	parameter int PRIO_W = 3,
	parameter logic [7:0] PORT_IDENTIFIER = 8'h11,
	parameter logic [3:0] PORT_CLASS = DCP_CLASS_NONE,
	parameter logic [6:0] MAKER_IDENTITY_CODE = 7'h15, // arbitrary value
	parameter logic [3:0] MAKER_CONTINUATION_CODE = 4'h3, // arbitrary value
	parameter logic [3:0] PORT_REVISION = 4'h1 // arbitrary value
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic link_clk_in,
	input wire logic ap_req_in,
	input wire logic ap_write_in,
	input wire logic [DCP_ADDR_W-1:0] ap_addr_in,
	input wire logic [DCP_DATA_W-1:0] ap_wdata_in,
	input wire logic power_up_request_in,
	input wire logic port_lock_in,
	input wire logic system_off_in,
	input wire logic erase_done_in,
	input wire logic cpu_halted_in,
	input wire logic [PRIO_W-1:0] halt_prio_in,
	input wire logic [PRIO_W-1:0] irq_prio_in,
	output logic ap_ack_out,
	output logic [DCP_DATA_W-1:0] ap_rdata_out,
	output logic soft_reset_hold_out,
	output logic erase_start_out,
	output logic erase_user_config_out,
	output logic debug_mode_out,
	output logic wake_out,
	output logic debug_wake_flag_set_out,
	output logic irq_run_allow_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dcp_state_t s_q;
	dcp_state_t s_d;
	logic [DCP_DATA_W-1:0] ident_word;
	logic link_rise;
	logic take;
	logic pwr_rise;
	logic powered;
	logic wr_strobe;
	logic rd_strobe;
	logic hit_hold;
	logic hit_erase;
	logic hit_state;
	logic hit_lock;
	logic hit_ident;
	logic hold_wr_en;
	logic hold_wr_val;
	logic erase_req;
	logic wake_req;
	logic irq_next;
	logic [DCP_DATA_W-1:0] read_word;

	// ----------------------------------------------------------------
	// link edge and request qualification
	// ----------------------------------------------------------------
	always_comb begin
		// requests are taken on a link clock rising edge, so bus fields
		// have had a full link half-period to settle through the flops
		link_rise = s_q.clk_s2 && !s_q.clk_s3;
		// lock input plays no part here: the port stays reachable
		take = link_rise && s_q.req_s2 && (s_q.hs == DCP_HS_IDLE);
		pwr_rise = s_q.pwr_s2 && !s_q.pwr_prev;
		// accesses without power-up are answered but change nothing
		powered = s_q.pwr_s2;
		wr_strobe = take && powered && s_q.wr_s2;
		rd_strobe = take && powered && !s_q.wr_s2;
	end

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	always_comb begin
		hit_hold = (s_q.addr_s2 == DCP_OFS_SOFT_RESET_HOLD);
		hit_erase = (s_q.addr_s2 == DCP_OFS_CHIP_ERASE_COMMAND);
		hit_state = (s_q.addr_s2 == DCP_OFS_CHIP_ERASE_STATE);
		hit_lock = (s_q.addr_s2 == DCP_OFS_LOCK_STATE);
		hit_ident = (s_q.addr_s2 == DCP_OFS_PORT_IDENT_WORD);
	end

	// ----------------------------------------------------------------
	// write side effects
	// ----------------------------------------------------------------
	always_comb begin
		hold_wr_en = wr_strobe && hit_hold;
		hold_wr_val = s_q.wdata_s2[DCP_BIT_FLAG];
		// only a written 1 starts an erase; 0 is a no-op
		erase_req = wr_strobe && hit_erase
			&& (s_q.wdata_s2[DCP_BIT_FLAG] != DCP_NO_ACTION);
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// unmapped, write-only and unpowered reads all return zero
	always_comb begin
		read_word = DCP_RESET_WORD;
		if (rd_strobe) begin
			if (hit_hold) begin
				read_word[DCP_BIT_FLAG] = s_q.rst_hold;
			end else if (hit_state) begin
				read_word[DCP_BIT_FLAG] = s_q.busy;
			end else if (hit_lock) begin
				// reads 0 while protection is active
				read_word[DCP_BIT_FLAG] = !s_q.lock_s2;
			end else if (hit_ident) begin
				read_word = ident_word;
			end else begin
				read_word = DCP_RESET_WORD;
			end
		end
	end

	// ----------------------------------------------------------------
	// wake and interrupt pass
	// ----------------------------------------------------------------
	always_comb begin
		wake_req = pwr_rise && system_off_in;
		// lower number is higher priority; equal priority must wait
		irq_next = !cpu_halted_in || (irq_prio_in < halt_prio_in);
	end

	// ----------------------------------------------------------------
	// identification word
	// ----------------------------------------------------------------
	always_comb begin
		ident_word = DCP_RESET_WORD;
		ident_word[DCP_IDENT_PORT_LSB +: 8] = PORT_IDENTIFIER;
		ident_word[DCP_IDENT_CLASS_LSB +: 4] = PORT_CLASS;
		ident_word[DCP_IDENT_MAKER_LSB +: 7] = MAKER_IDENTITY_CODE;
		ident_word[DCP_IDENT_CONT_LSB +: 4] = MAKER_CONTINUATION_CODE;
		ident_word[DCP_IDENT_REV_LSB +: 4] = PORT_REVISION;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// everything from the link passes two flops before use
		s_d.clk_s1 = link_clk_in;
		s_d.clk_s2 = s_q.clk_s1;
		s_d.clk_s3 = s_q.clk_s2;
		s_d.req_s1 = ap_req_in;
		s_d.req_s2 = s_q.req_s1;
		s_d.wr_s1 = ap_write_in;
		s_d.wr_s2 = s_q.wr_s1;
		s_d.addr_s1 = ap_addr_in;
		s_d.addr_s2 = s_q.addr_s1;
		s_d.wdata_s1 = ap_wdata_in;
		s_d.wdata_s2 = s_q.wdata_s1;
		s_d.pwr_s1 = power_up_request_in;
		s_d.pwr_s2 = s_q.pwr_s1;
		s_d.pwr_prev = s_q.pwr_s2;
		s_d.lock_s1 = port_lock_in;
		s_d.lock_s2 = s_q.lock_s1;
		s_d.erase_start = 1'b0;
		s_d.erase_config = 1'b0;
		s_d.wake = 1'b0;
		s_d.wake_flag = 1'b0;

		// erase finishes on its own; a new start in the same cycle wins
		if (erase_done_in) begin
			s_d.busy = 1'b0;
		end

		case (s_q.hs)
			DCP_HS_IDLE: begin
				if (take) begin
					s_d.hs = DCP_HS_WAIT_DROP;
					s_d.ack = 1'b1;
					s_d.rdata = read_word;
					if (hold_wr_en) begin
						s_d.rst_hold = hold_wr_val;
					end
					if (erase_req) begin
						s_d.erase_start = 1'b1;
						s_d.erase_config = 1'b1;
						s_d.busy = 1'b1;
					end
				end
			end
			DCP_HS_WAIT_DROP: begin
				if (!s_q.req_s2) begin
					s_d.hs = DCP_HS_IDLE;
					s_d.ack = 1'b0;
				end
			end
			default: begin
				s_d.hs = DCP_HS_IDLE;
				s_d.ack = 1'b0;
			end
		endcase

		// ------------------------------------------------------------
		// debug interface mode and wake from system off
		// ------------------------------------------------------------
		s_d.dbg_mode = s_q.pwr_s2;
		if (wake_req) begin
			s_d.wake = 1'b1;
			s_d.wake_flag = 1'b1;
		end
		s_d.irq_allow = irq_next;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_q <= '0;
			s_q.hs <= DCP_HS_IDLE;
			s_q.rst_hold <= DCP_RESET_RELEASED;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ap_ack_out = s_q.ack;
	assign ap_rdata_out = s_q.rdata;
	assign soft_reset_hold_out = s_q.rst_hold;
	assign erase_start_out = s_q.erase_start;
	assign erase_user_config_out = s_q.erase_config;
	assign debug_mode_out = s_q.dbg_mode;
	assign wake_out = s_q.wake;
	assign debug_wake_flag_set_out = s_q.wake_flag;
	assign irq_run_allow_out = s_q.irq_allow;
endmodule : dcp_control_port

//--- verif/dcp_probe.sv
// debug probe model: link clock and power-up request
`timescale 1ns/1ns
module dcp_probe (
	input wire logic run_in,
	input wire logic pwr_in,
	output logic link_clk_out,
	output logic power_up_request_out
);
	// clock rests low between frames, where the pull-down leaves it
	initial begin
		link_clk_out = 1'b0;
		forever begin
			wait (run_in);
			#62 link_clk_out = 1'b1;
			#63 link_clk_out = 1'b0;
		end
	end
	assign power_up_request_out = pwr_in;
endmodule : dcp_probe

//--- verif/dcp_control_port_properties.sv
// concurrent checks on the debug control port
`timescale 1ns/1ns
module dcp_control_port_properties
	import dcp_pkg::*;
#(
	parameter int PRIO_W = 3
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ap_req_in,
	input wire logic power_up_request_in,
	input wire logic system_off_in,
	input wire logic cpu_halted_in,
	input wire logic [PRIO_W-1:0] halt_prio_in,
	input wire logic [PRIO_W-1:0] irq_prio_in,
	input wire logic ap_ack_out,
	input wire logic soft_reset_hold_out,
	input wire logic erase_start_out,
	input wire logic erase_user_config_out,
	input wire logic debug_mode_out,
	input wire logic wake_out,
	input wire logic debug_wake_flag_set_out,
	input wire logic irq_run_allow_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// request seen low long enough to pass the synchroniser
	sequence s_req_gone;
		!ap_req_in [*4];
	endsequence
	a_ack_release: assert property (s_req_gone |-> !ap_ack_out) else $error("ack held");
	a_ack_stand: assert property (ap_ack_out && ap_req_in |=> ap_ack_out) else $error("ack lost");
	a_erase_pair: assert property (erase_start_out |-> erase_user_config_out && $rose(ap_ack_out))
		else $error("erase start");
	a_hold_cause: assert property ($changed(soft_reset_hold_out) |-> $rose(ap_ack_out))
		else $error("hold moved");
	a_mode_follow: assert property ($rose(power_up_request_in) |-> ##[2:4] debug_mode_out)
		else $error("no mode");
	a_mode_drop: assert property ($fell(power_up_request_in) |-> ##[2:4] !debug_mode_out)
		else $error("mode kept");
	a_wake_once: assert property ($rose(power_up_request_in) && system_off_in
		|-> ##[2:4] wake_out && debug_wake_flag_set_out) else $error("no wake");
	a_irq_block: assert property (cpu_halted_in && irq_prio_in >= halt_prio_in
		|=> !irq_run_allow_out) else $error("irq let");
	a_irq_pass: assert property (!cpu_halted_in || irq_prio_in < halt_prio_in
		|=> irq_run_allow_out) else $error("irq held");
endmodule : dcp_control_port_properties
bind dcp_control_port dcp_control_port_properties #(.PRIO_W(PRIO_W)) u_props (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .ap_req_in(ap_req_in),
	.power_up_request_in(power_up_request_in), .system_off_in(system_off_in),
	.cpu_halted_in(cpu_halted_in), .halt_prio_in(halt_prio_in), .irq_prio_in(irq_prio_in),
	.ap_ack_out(ap_ack_out), .soft_reset_hold_out(soft_reset_hold_out),
	.erase_start_out(erase_start_out), .erase_user_config_out(erase_user_config_out),
	.debug_mode_out(debug_mode_out), .wake_out(wake_out),
	.debug_wake_flag_set_out(debug_wake_flag_set_out), .irq_run_allow_out(irq_run_allow_out));

//--- verif/dcp_control_port_tb.sv
// self-checking bench for the debug control port
`timescale 1ns/1ns
module dcp_control_port_tb;
	logic clk_in = 1'b0, rst_b_in = 1'b0, run = 1'b0, pwr = 1'b0, req = 1'b0, wr = 1'b0;
	logic lock = 1'b1, off = 1'b0, done = 1'b0, halted = 1'b0, lclk, pur, ack, hold, dbg, allow;
	logic [2:0] hp = 3'h0, ip = 3'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0, rd, got, seed = 32'h0001_2e6b;
	int fail_count = 0, comparisons = 0, n_erase = 0, n_wake = 0;
	logic est, wk;
	always @(posedge clk_in) begin
		if (est === 1'b1) n_erase <= n_erase + 1;
		if (wk === 1'b1) n_wake <= n_wake + 1;
	end
	initial forever #4 clk_in = ~clk_in;
	dcp_probe probe (.run_in(run), .pwr_in(pwr), .link_clk_out(lclk), .power_up_request_out(pur));
	dcp_control_port DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .link_clk_in(lclk),
		.ap_req_in(req), .ap_write_in(wr), .ap_addr_in(addr), .ap_wdata_in(wd),
		.power_up_request_in(pur), .port_lock_in(lock), .system_off_in(off),
		.erase_done_in(done), .cpu_halted_in(halted), .halt_prio_in(hp), .irq_prio_in(ip),
		.ap_ack_out(ack), .ap_rdata_out(rd), .soft_reset_hold_out(hold), .erase_start_out(est),
		.erase_user_config_out(), .debug_mode_out(dbg), .wake_out(wk),
		.debug_wake_flag_set_out(), .irq_run_allow_out(allow));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wait_ack(input logic lvl);
		for (int n = 0; ack !== lvl; n++) begin
			@(negedge clk_in);
			if (n > 200) begin
				chk(ack, lvl);
				finish_test();
			end
		end
	endtask : wait_ack
	// four-phase access; link clock runs only for the frame
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_in);
		wr = w;
		addr = a;
		wd = d;
		req = 1'b1;
		run = 1'b1;
		wait_ack(1'b1);
		got = rd;
		req = 1'b0;
		wait_ack(1'b0);
		run = 1'b0;
	endtask : acc
	initial begin
		repeat (2) @(negedge clk_in);
		rst_b_in = 1'b1;
		off = 1'b1;
		pwr = 1'b1;
		repeat (6) @(negedge clk_in);
		chk(dbg, 32'h1);
		chk(n_wake, 32'h1);
		off = 1'b0;
		acc(1'b1, 8'hfc, 32'hffff_ffff);
		acc(1'b0, 8'hfc, 32'h0);
		chk(got, {4'h1, 4'h3, 7'h15, 4'h0, 5'h00, 8'h11});
		acc(1'b0, 8'h0c, 32'h0);
		chk(got, 32'h0);
		lock = 1'b0;
		acc(1'b0, 8'h0c, 32'h0);
		chk(got, 32'h1);
		acc(1'b1, 8'h04, 32'h0);
		acc(1'b0, 8'h08, 32'h0);
		chk(got, 32'h0);
		chk(n_erase, 32'h0);
		acc(1'b1, 8'h04, 32'h1);
		acc(1'b0, 8'h08, 32'h0);
		chk(got, 32'h1);
		chk(n_erase, 32'h1);
		done = 1'b1;
		@(negedge clk_in);
		done = 1'b0;
		acc(1'b0, 8'h08, 32'h0);
		chk(got, 32'h0);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			acc(1'b1, 8'h00, seed);
			acc(1'b0, 8'h00, 32'h0);
			chk(got, {31'h0, seed[0]});
			chk(hold, seed[0]);
			halted = seed[1];
			hp = seed[4:2];
			ip = seed[7:5];
			repeat (2) @(negedge clk_in);
			chk(allow, !seed[1] || seed[7:5] < seed[4:2]);
		end
		acc(1'b1, 8'h00, 32'h0);
		chk(hold, 32'h0);
		pwr = 1'b0;
		repeat (6) @(negedge clk_in);
		chk(dbg, 32'h0);
		finish_test();
	end
endmodule : dcp_control_port_tb
